// >>> vgs_pkg.sv
`default_nettype none

package vgs_pkg;

	// directly decoded legacy port addresses
	localparam logic [15:0] PORT_STATUS_MONO  = 16'h03BA;
	localparam logic [15:0] PORT_STATUS_COLOR = 16'h03DA;
	localparam logic [15:0] PORT_MISC_WR      = 16'h03C2;
	localparam logic [15:0] PORT_SENSE_RD     = 16'h03C2;
	localparam logic [15:0] PORT_FEATURE_RD   = 16'h03CA;
	localparam logic [15:0] PORT_MISC_RD      = 16'h03CC;

	// misc output control fields
	localparam int MISC_VSYNC_NEG  = 7;
	localparam int MISC_HSYNC_NEG  = 6;
	localparam int MISC_PAGE_LOWER = 5;
	localparam int MISC_CLK_HI     = 3;
	localparam int MISC_CLK_LO     = 2;
	localparam int MISC_APERTURE   = 1;
	localparam int MISC_RANGE_SEL  = 0;
	localparam logic [7:0] MISC_WR_MASK = 8'hEF;
	localparam logic [7:0] MISC_RESET   = 8'h00;

	// feature control field
	localparam int FEAT_VSYNC_CTRL = 3;
	localparam logic FEAT_RESET    = 1'b0;

	// input status fields
	localparam int SENSE_PENDING   = 7;
	localparam int SENSE_COMPARE   = 4;
	localparam int TIMING_FB_HI    = 5;
	localparam int TIMING_FB_LO    = 4;
	localparam int TIMING_VRETRACE = 3;
	localparam int TIMING_BLANK    = 0;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// dot clock select codes
	localparam logic [1:0] DOT_CLOCK_LOW  = 2'b00;
	localparam logic [1:0] DOT_CLOCK_HIGH = 2'b01;

	// host port request
	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} vgs_io_req_t;

	// raw timing status from the pixel generator and the assigned pipe
	typedef struct packed {
		logic       vga_vretrace;
		logic       vga_blank;
		logic       pipe_vretrace;
		logic       pipe_blank;
		logic [7:0] palette_color;
	} vgs_timing_t;

endpackage : vgs_pkg

`default_nettype wire

// >>> vgs_general_regs.sv
// What this block does
// - pending-retrace flag, bit 7 of sense status, always reads zero.
// - monitor sense bit 4 of sense status always reads one.
// - range-select bit picks 3Bxh (0) or 3Dxh (1) for status and feature ports.
// - this build claims both mono and colour ranges regardless of range select.
// - timing status bits 5:4 mirror two palette colour bits chosen by plane enable.
// - timing status bit 3 reads one during vertical retrace of pixel generation.
// - with VGA disabled, vertical retrace status comes from the assigned pipe.
// - no interrupt is ever raised from retrace control bits.
// - timing status bit 0 reads zero in active display, one while blanking.
// - blank status also comes from the assigned pipe when VGA is disabled.
// - feature control written at selected status port, read back at 3CAh.
// - feature bit 3 is plain storage with no effect on sync.
// - feature bits 1 and 0 always read zero.
// - misc output written at 3C2h, read back at 3CCh.
// - misc bits 7,6 set sync polarity in native mode; else port control.
// - in odd/even mode misc bit 5 picks page: 0 upper, 1 lower.
// - misc bit 1 gates the A0000-BFFFFh aperture only.
// - every register sits at its own port, no index sequence.
`timescale 1ns/100ps
`default_nettype none

module vgs_general_regs #(
	parameter bit CLAIM_BOTH_RANGES = 1'b1
) (
	input  wire logic                CLK,
	input  wire logic                NRST,
	input  wire vgs_pkg::vgs_io_req_t IO_REQ,
	output logic                     IO_CLAIM,
	output logic [7:0]               IO_RDATA,
	output logic                     IO_RVALID,
	input  wire vgs_pkg::vgs_timing_t TIMING_IN,
	input  wire logic                VGA_DISABLE,
	input  wire logic [1:0]          COLOUR_PLANE_SEL,
	input  wire logic                NATIVE_MODE,
	input  wire logic                ODD_EVEN_MODE,
	input  wire logic                PORT_VSYNC_NEG,
	input  wire logic                PORT_HSYNC_NEG,
	output logic                     VSYNC_NEG,
	output logic                     HSYNC_NEG,
	output logic                     PAGE_SELECT_VALID,
	output logic                     PAGE_LOWER,
	output logic [1:0]               DOT_CLOCK_SEL,
	output logic                     DOT_CLOCK_HIGH_SEL,
	output logic                     LEGACY_APERTURE_EN,
	output logic                     COLOR_RANGE_SEL
);
	import vgs_pkg::*;

	// whole block state, one record
	typedef struct packed {
		logic [7:0] misc;
		logic       feat_vsync;
		logic [7:0] rdata;
		logic       rvalid;
		logic [1:0] vga_vr_s;
		logic [1:0] vga_bl_s;
		logic [1:0] pipe_vr_s;
		logic [1:0] pipe_bl_s;
		logic [1:0] fb_hi_s;
		logic [1:0] fb_lo_s;
	} vgs_state_t;

	localparam vgs_state_t STATE_RESET = '{
		misc:       MISC_RESET,
		feat_vsync: FEAT_RESET,
		rdata:      RDATA_RESET,
		rvalid:     1'b0,
		vga_vr_s:   2'b00,
		vga_bl_s:   2'b00,
		pipe_vr_s:  2'b00,
		pipe_bl_s:  2'b00,
		fb_hi_s:    2'b00,
		fb_lo_s:    2'b00
	};

	vgs_state_t state_ff;
	vgs_state_t nxt_state;

	// colour feedback pair chosen by the plane enable field; {hi, lo}
	function automatic logic [1:0] fb_pick(
		input logic [7:0] color,
		input logic [1:0] sel
	);
		logic [1:0] pair;
		pair = 2'b00;
		unique case (sel)
			2'b00: pair = {color[2], color[0]};
			2'b01: pair = {color[5], color[4]};
			2'b10: pair = {color[3], color[1]};
			2'b11: pair = {color[7], color[6]};
		endcase
		return pair;
	endfunction : fb_pick

	// status port address in the given range, or in either range when CLAIM_BOTH_RANGES is set
	function automatic logic status_hit(
		input logic [15:0] addr,
		input logic        color_sel
	);
		logic mono_hit;
		logic color_hit;
		mono_hit  = (addr == PORT_STATUS_MONO);
		color_hit = (addr == PORT_STATUS_COLOR);
		if (CLAIM_BOTH_RANGES) begin
			return mono_hit | color_hit;
		end
		return color_sel ? color_hit : mono_hit;
	endfunction : status_hit

	// address decode, each register at its own port
	logic       hit_status;
	logic       hit_misc_wr;
	logic       hit_sense_rd;
	logic       hit_feat_rd;
	logic       hit_misc_rd;
	logic [1:0] fb_raw;
	logic       vr_sel;
	logic       bl_sel;
	logic [7:0] sense_word;
	logic [7:0] timing_word;
	logic [7:0] feat_word;
	logic [7:0] misc_word;

	always_comb begin
		hit_status   = status_hit(IO_REQ.addr, state_ff.misc[MISC_RANGE_SEL]);
		hit_misc_wr  = IO_REQ.wr & (IO_REQ.addr == PORT_MISC_WR);
		hit_sense_rd = IO_REQ.rd & (IO_REQ.addr == PORT_SENSE_RD);
		hit_feat_rd  = IO_REQ.rd & (IO_REQ.addr == PORT_FEATURE_RD);
		hit_misc_rd  = IO_REQ.rd & (IO_REQ.addr == PORT_MISC_RD);
	end

	// claim is a handshake answer to the current strobe
	assign IO_CLAIM = (hit_status & (IO_REQ.rd | IO_REQ.wr)) | hit_misc_wr
		| hit_sense_rd | hit_feat_rd | hit_misc_rd;

	// the mux sits ahead of the first flop so only two bits cross
	assign fb_raw = fb_pick(TIMING_IN.palette_color, COLOUR_PLANE_SEL);

	// source switch after synchronisation; disable is a same-clock level
	assign vr_sel = VGA_DISABLE ? state_ff.pipe_vr_s[1] : state_ff.vga_vr_s[1];
	assign bl_sel = VGA_DISABLE ? state_ff.pipe_bl_s[1] : state_ff.vga_bl_s[1];

	// read words, reserved bits zero
	always_comb begin
		sense_word = 8'h00;
		sense_word[SENSE_PENDING] = 1'b0;
		sense_word[SENSE_COMPARE] = 1'b1;
		timing_word = 8'h00;
		timing_word[TIMING_FB_HI]    = state_ff.fb_hi_s[1];
		timing_word[TIMING_FB_LO]    = state_ff.fb_lo_s[1];
		timing_word[TIMING_VRETRACE] = vr_sel;
		timing_word[TIMING_BLANK]    = bl_sel;
		feat_word = 8'h00;
		feat_word[FEAT_VSYNC_CTRL] = state_ff.feat_vsync;
		misc_word = state_ff.misc & MISC_WR_MASK;
	end

	// next state: synchronisers, register writes, registered read data
	always_comb begin
		nxt_state = state_ff;
		// two flops per crossing bit, stage 0 read only by stage 1
		nxt_state.vga_vr_s  = {state_ff.vga_vr_s[0], TIMING_IN.vga_vretrace};
		nxt_state.vga_bl_s  = {state_ff.vga_bl_s[0], TIMING_IN.vga_blank};
		nxt_state.pipe_vr_s = {state_ff.pipe_vr_s[0], TIMING_IN.pipe_vretrace};
		nxt_state.pipe_bl_s = {state_ff.pipe_bl_s[0], TIMING_IN.pipe_blank};
		nxt_state.fb_hi_s   = {state_ff.fb_hi_s[0], fb_raw[1]};
		nxt_state.fb_lo_s   = {state_ff.fb_lo_s[0], fb_raw[0]};

		// reserved misc bit 4 is never stored
		if (hit_misc_wr) begin
			nxt_state.misc = IO_REQ.wdata & MISC_WR_MASK;
		end
		// only bit 3 has storage; bits 1:0 and the rest stay zero
		if (IO_REQ.wr & hit_status) begin
			nxt_state.feat_vsync = IO_REQ.wdata[FEAT_VSYNC_CTRL];
		end

		// read answer one cycle after the strobe; miss returns zero
		nxt_state.rvalid = IO_REQ.rd;
		nxt_state.rdata  = 8'h00;
		if (hit_sense_rd) begin
			nxt_state.rdata = sense_word;
		end else if (IO_REQ.rd & hit_status) begin
			nxt_state.rdata = timing_word;
		end else if (hit_feat_rd) begin
			nxt_state.rdata = feat_word;
		end else if (hit_misc_rd) begin
			nxt_state.rdata = misc_word;
		end
	end

	// single register stage for all state
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_ff <= STATE_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign IO_RDATA  = state_ff.rdata;
	assign IO_RVALID = state_ff.rvalid;

	// sync polarity only from legacy bits in native mode
	assign VSYNC_NEG = NATIVE_MODE ? state_ff.misc[MISC_VSYNC_NEG] : PORT_VSYNC_NEG;
	assign HSYNC_NEG = NATIVE_MODE ? state_ff.misc[MISC_HSYNC_NEG] : PORT_HSYNC_NEG;

	// page select means something only in odd/even map mode
	assign PAGE_SELECT_VALID = ODD_EVEN_MODE;
	assign PAGE_LOWER        = ODD_EVEN_MODE & state_ff.misc[MISC_PAGE_LOWER];

	// codes 10 and 11 pass through but select neither source
	assign DOT_CLOCK_SEL      = state_ff.misc[MISC_CLK_HI:MISC_CLK_LO];
	assign DOT_CLOCK_HIGH_SEL = (DOT_CLOCK_SEL == DOT_CLOCK_HIGH);

	// gates the legacy window only, the linear buffer is not touched here
	assign LEGACY_APERTURE_EN = state_ff.misc[MISC_APERTURE];
	assign COLOR_RANGE_SEL    = state_ff.misc[MISC_RANGE_SEL];

	// no interrupt output exists; retrace status is poll-only

endmodule : vgs_general_regs

`default_nettype wire

// >>> vgs_general_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module vgs_general_regs_checker (
	input wire logic                 CLK,
	input wire logic                 NRST,
	input wire vgs_pkg::vgs_io_req_t IO_REQ,
	input wire logic                 IO_CLAIM,
	input wire logic [7:0]           IO_RDATA,
	input wire logic                 IO_RVALID,
	input wire logic                 NATIVE_MODE,
	input wire logic                 PORT_VSYNC_NEG,
	input wire logic                 VSYNC_NEG,
	input wire logic [1:0]           DOT_CLOCK_SEL,
	input wire logic                 DOT_CLOCK_HIGH_SEL,
	input wire logic                 LEGACY_APERTURE_EN
);
	import vgs_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	// misc write followed straight away by its readback
	sequence s_misc_wr;
		IO_REQ.wr && IO_REQ.addr == PORT_MISC_WR;
	endsequence
	sequence s_misc_rd;
		IO_REQ.rd && IO_REQ.addr == PORT_MISC_RD;
	endsequence
	misc_readback_a: assert property (s_misc_wr ##1 s_misc_rd |=>
		IO_RDATA == ($past(IO_REQ.wdata, 2) & MISC_WR_MASK)) else $error("misc readback wrong");
	read_answer_a: assert property (IO_REQ.rd |=> IO_RVALID)
		else $error("read not answered");
	sense_value_a: assert property (IO_REQ.rd && IO_REQ.addr == PORT_SENSE_RD
		|=> IO_RDATA == 8'h10) else $error("sense value wrong");
	both_ranges_a: assert property ((IO_REQ.rd || IO_REQ.wr) &&
		(IO_REQ.addr == PORT_STATUS_MONO || IO_REQ.addr == PORT_STATUS_COLOR) |-> IO_CLAIM)
		else $error("status port not claimed");
	feat_bits_a: assert property (IO_REQ.rd && IO_REQ.addr == PORT_FEATURE_RD
		|=> (IO_RDATA & 8'hF7) == 8'h00) else $error("feature spare bits set");
	dot_decode_a: assert property (DOT_CLOCK_HIGH_SEL == (DOT_CLOCK_SEL == DOT_CLOCK_HIGH))
		else $error("dot clock decode wrong");
	aperture_gate_a: assert property (s_misc_wr |=>
		LEGACY_APERTURE_EN == $past(IO_REQ.wdata[1])) else $error("aperture not updated");
	port_polarity_a: assert property (!NATIVE_MODE |-> VSYNC_NEG == PORT_VSYNC_NEG)
		else $error("polarity not from port");
endmodule : vgs_general_regs_checker
bind vgs_general_regs vgs_general_regs_checker vgs_general_regs_checker_i (.CLK, .NRST,
	.IO_REQ, .IO_CLAIM, .IO_RDATA, .IO_RVALID, .NATIVE_MODE, .PORT_VSYNC_NEG, .VSYNC_NEG,
	.DOT_CLOCK_SEL, .DOT_CLOCK_HIGH_SEL, .LEGACY_APERTURE_EN);
`default_nettype wire

// >>> vgs_timing_model.sv
`timescale 1ns/100ps
`default_nettype none
module vgs_timing_model (
	input wire logic                 CLK,
	input wire vgs_pkg::vgs_timing_t SET,
	output var vgs_pkg::vgs_timing_t TIMING
);
	import vgs_pkg::*;
	// video timing runs unrelated to the bus, so levels move off the rising edge;
	// one driver only, the bench holds reset until the first levels are out
	always @(negedge CLK) begin
		TIMING <= SET;
	end
endmodule : vgs_timing_model
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import vgs_pkg::*;
	logic CLK = 0, NRST = 0, vdis = 0, nat = 0, oe = 0, pv = 0;
	logic claim, rvalid, vneg, hneg, plow, dhi, apen, rsel;
	logic [7:0] rdata, d;
	logic [1:0] dsel, cps = 2'b00;
	vgs_io_req_t req = '0;
	vgs_timing_t tset = '0, tim;
	int err_count = 0, n_tests = 0, cyc = 0;
	// feedback pairs for palette a5 with plane select 3..0
	localparam logic [7:0] FB_TAB = 8'h8B;
	always #20 CLK = ~CLK;
	vgs_timing_model vgs_timing_model_i (.CLK(CLK), .SET(tset), .TIMING(tim));
	vgs_general_regs vgs_general_regs_i (.CLK(CLK), .NRST(NRST), .IO_REQ(req),
		.IO_CLAIM(claim), .IO_RDATA(rdata), .IO_RVALID(rvalid), .TIMING_IN(tim),
		.VGA_DISABLE(vdis), .COLOUR_PLANE_SEL(cps), .NATIVE_MODE(nat), .ODD_EVEN_MODE(oe),
		.PORT_VSYNC_NEG(pv), .PORT_HSYNC_NEG(1'b0), .VSYNC_NEG(vneg), .HSYNC_NEG(hneg),
		.PAGE_SELECT_VALID(), .PAGE_LOWER(plow), .DOT_CLOCK_SEL(dsel),
		.DOT_CLOCK_HIGH_SEL(dhi), .LEGACY_APERTURE_EN(apen), .COLOR_RANGE_SEL(rsel));
	task automatic final_report;
		if (err_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// request held until the next access replaces it, so calls run back to back;
	// byte-wide single accesses only, never a wider port operation
	task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] wd,
		input logic cl, input logic [7:0] exp);
		req = '{addr: a, rd: !w, wr: w, wdata: wd};
		#1;
		chk({7'b0, claim}, {7'b0, cl});
		@(negedge CLK);
		if (!w) begin
			chk({7'b0, rvalid}, 8'h01);
			chk(rdata, exp);
		end
	endtask : acc
	// two harmless reads let the status synchroniser settle
	task automatic gap;
		repeat (2) acc(PORT_SENSE_RD, 0, 0, 1, 8'h10);
	endtask : gap
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 1000) begin
			err_count++;
			final_report();
		end
	end
	initial begin
		repeat (12) @(negedge CLK);
		NRST = 1;
		nat = 1;
		oe = 1;
		acc(PORT_MISC_RD, 0, 0, 1, MISC_RESET);
		acc(PORT_FEATURE_RD, 0, 0, 1, 8'h00);
		acc(16'h03C0, 0, 0, 0, 8'h00);
		acc(16'h03C0, 1, 8'hFF, 0, 8'h00);
		// every dot clock code, other misc bits varied, spare bit 4 always written
		for (int i = 0; i < 4; i++) begin
			d = {i[1], i[0], i[0], 1'b1, i[1:0], i[0], i[1]};
			acc(PORT_MISC_WR, 1, d, 1, 8'h00);
			acc(PORT_MISC_RD, 0, 0, 1, d & 8'hEF);
			chk({dhi, dsel}, {i == 1, i[1:0]});
			chk({vneg, hneg}, d[7:6]);
			chk({plow, apen, rsel}, {d[5], d[1], d[0]});
		end
		nat = 0;
		oe = 0;
		pv = 1;
		acc(PORT_STATUS_MONO, 1, 8'hFF, 1, 8'h00);
		chk({vneg, hneg, plow}, 8'h04);
		acc(PORT_FEATURE_RD, 0, 0, 1, 8'h08);
		acc(PORT_STATUS_COLOR, 1, 8'h00, 1, 8'h00);
		acc(PORT_FEATURE_RD, 0, 0, 1, 8'h00);
		tset = '{vga_vretrace: 1, vga_blank: 0, pipe_vretrace: 0, pipe_blank: 1,
			palette_color: 8'hA5};
		gap();
		for (int s = 0; s < 4; s++) begin
			cps = s[1:0];
			gap();
			acc(PORT_STATUS_COLOR, 0, 0, 1, {2'b0, FB_TAB[2*s+:2], 4'h8});
		end
		vdis = 1;
		gap();
		acc(PORT_STATUS_MONO, 0, 0, 1, 8'h21);
		// mid-run reset must bring stored settings back to their defaults
		NRST = 0;
		@(negedge CLK);
		NRST = 1;
		acc(PORT_MISC_RD, 0, 0, 1, MISC_RESET);
		acc(PORT_FEATURE_RD, 0, 0, 1, 8'h00);
		req = '0;
		@(negedge CLK);
		final_report();
	end
endmodule : testbench
`default_nettype wire
